//--- hdl/tur_top.sv
// Request decoder and report generator of a USB touch controller.
// Assumes an SIE on the same clock hands over whole setup packets and
// drains the report endpoint one byte at a time.
//
// Summary of operation
// - Behave as a USB 1.1 compliant device.
// - All commands are vendor requests and reports.
// - Fixed vendor id, mode picks product id.
// - Accept only codes 4,6,7,8,10,16.
// - Setup fields at byte offsets 0,1,2,4,6.
// - Request type: direction, type, recipient fields.
// - Sync reports 4, 6, 12 answer requests.
// - Coordinate report runs from power-up, asynchronously.
// - Coordinate report byte layout, id 0x01.
// - Loop counter stamps one processing tick.
// - Status bit7 one, bit6 touch.
// - Raw coordinates signed, -8192 to 8191.
// - Compensated coordinates via calibration, 0 to 65535.
// - Two-byte fields leave low byte first.
// - Stream reports continuously while touched.
// - Malformed, unpermitted or unsupported requests fail.
// - Failed requests stall endpoint zero.
`timescale 1ns/100ps
`default_nettype none
module tur_top
    import tur_pkg::*;
#(
    parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value.
    parameter logic [15:0] PID_NORMAL = 16'h0a01, // Arbitrary value.
    parameter logic [15:0] PID_SPECIAL = 16'h0a02 // Arbitrary value.
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic SPECIAL_MODE,
    input wire logic SETUP_VALID,
    input wire logic [63:0] SETUP_DATA,
    input wire logic CMD_PERMIT,
    input wire logic SAMPLE_TICK,
    input wire logic TOUCHED,
    input wire logic [13:0] RAW_X,
    input wire logic [13:0] RAW_Y,
    input wire logic CAL_WE,
    input wire logic [15:0] CAL_X_OFF,
    input wire logic [15:0] CAL_X_GAIN,
    input wire logic [15:0] CAL_Y_OFF,
    input wire logic [15:0] CAL_Y_GAIN,
    input wire logic REP_READY,
    output logic [15:0] VID,
    output logic [15:0] PID,
    output logic USB_REV11,
    output logic CMD_VALID,
    output logic [7:0] CMD_CODE,
    output logic [15:0] CMD_VALUE,
    output logic [15:0] CMD_INDEX,
    output logic [15:0] CMD_LENGTH,
    output logic SYNC_REQ,
    output logic [7:0] SYNC_ID,
    output logic EP0_STALL,
    output logic [7:0] LOOP_COUNT,
    output logic [7:0] REP_DATA,
    output logic REP_VALID,
    output logic REP_LAST
);

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------

    // Only the six vendor commands are known.
    function automatic logic cmd_known(input logic [7:0] c);
        case (c)
            CMD_CALIBRATE, CMD_STATUS, CMD_RESET, CMD_DEFAULTS,
            CMD_CTRL_ID, CMD_READ_PARAM: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    endfunction

    // Report returned by a command, zero for commands with no data.
    function automatic logic [7:0] cmd_report(input logic [7:0] c);
        case (c)
            CMD_STATUS: cmd_report = RPT_STATUS;
            CMD_CTRL_ID: cmd_report = RPT_CTRL_ID;
            CMD_READ_PARAM: cmd_report = RPT_PARAM;
            default: cmd_report = 8'h00;
        endcase
    endfunction

    // Picks one byte out of the little-endian setup packet.
    function automatic logic [7:0] setup_byte(input logic [63:0] p,
                                              input int ofs);
        setup_byte = p[ofs*8 +: 8];
    endfunction

    // Applies offset and gain, then clamps to the unsigned range.
    // The wide intermediate keeps overflow out of the clamp decision.
    function automatic logic [15:0] compensate(input logic [13:0] raw,
                                               input logic [15:0] off,
                                               input logic [15:0] gain);
        logic signed [17:0] diff;
        logic signed [35:0] prod;
        logic signed [35:0] scaled;
        diff = 18'(signed'(raw)) - 18'(signed'(off));
        prod = 36'(diff) * 36'(signed'({1'b0, gain}));
        scaled = prod >>> CAL_FRAC;
        if (scaled < 0) begin
            compensate = 16'h0000;
        end else if (scaled > 36'sh0ffff) begin
            compensate = 16'hffff;
        end else begin
            compensate = scaled[15:0];
        end
    endfunction

    // -------------------------------------------------------------
    // Identity
    // -------------------------------------------------------------
    logic mode_s1_q;
    logic mode_s2_q;

    // The mode strap comes from a pin, so it is synchronised first.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
        end else begin
            mode_s1_q <= SPECIAL_MODE;
            mode_s2_q <= mode_s1_q;
        end
    end

    // Vendor id is fixed, product id follows the mode strap.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            VID <= VENDOR_ID;
            PID <= PID_NORMAL;
            USB_REV11 <= 1'b1;
        end else begin
            VID <= VENDOR_ID;
            PID <= mode_s2_q ? PID_SPECIAL : PID_NORMAL;
            USB_REV11 <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Request decode
    // -------------------------------------------------------------
    logic [7:0] req_type;
    logic [7:0] req_code;
    logic [15:0] req_value;
    logic [15:0] req_index;
    logic [15:0] req_length;
    logic dir_in;
    logic form_ok;
    logic known;
    logic req_ok;

    // Field extraction from the eight setup bytes.
    assign req_type = setup_byte(SETUP_DATA, OFS_REQ_TYPE);
    assign req_code = setup_byte(SETUP_DATA, OFS_REQUEST);
    assign req_value = {setup_byte(SETUP_DATA, OFS_VALUE + 1),
                        setup_byte(SETUP_DATA, OFS_VALUE)};
    assign req_index = {setup_byte(SETUP_DATA, OFS_INDEX + 1),
                        setup_byte(SETUP_DATA, OFS_INDEX)};
    assign req_length = {setup_byte(SETUP_DATA, OFS_LENGTH + 1),
                         setup_byte(SETUP_DATA, OFS_LENGTH)};
    assign dir_in = req_type[BIT_DIR];
    assign known = cmd_known(req_code);

    // Well formed means vendor type to the device, with the direction
    // bit matching whether the command returns data. Standard and class
    // requests that reach this decoder fail and stall endpoint zero.
    always_comb begin
        form_ok = 1'b1;
        if (req_type[BIT_TYPE_HI:BIT_TYPE_LO] != TYPE_VENDOR) begin
            form_ok = 1'b0;
        end
        if (req_type[BIT_RECIP_HI:0] != RECIP_DEVICE) begin
            form_ok = 1'b0;
        end
        if (dir_in != (cmd_report(req_code) != 8'h00)) begin
            form_ok = 1'b0;
        end
        if (!dir_in && req_length != 16'h0000) begin
            form_ok = 1'b0; // Outgoing commands carry no data stage.
        end
        if (req_code == CMD_CALIBRATE && req_value != CAL_INSET &&
            req_value != CAL_CORNER) begin
            form_ok = 1'b0;
        end
    end

    // A request passes only if known, well formed and permitted now.
    assign req_ok = known && form_ok && CMD_PERMIT;

    // Accepted commands go out as a one-cycle pulse with their fields.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            CMD_VALID <= 1'b0;
            CMD_CODE <= 8'h00;
            CMD_VALUE <= 16'h0000;
            CMD_INDEX <= 16'h0000;
            CMD_LENGTH <= 16'h0000;
        end else begin
            CMD_VALID <= SETUP_VALID && req_ok;
            if (SETUP_VALID && req_ok) begin
                CMD_CODE <= req_code;
                CMD_VALUE <= req_value;
                CMD_INDEX <= req_index;
                CMD_LENGTH <= req_length;
            end
        end
    end

    // Data-returning commands ask for their report at once; a failed
    // request stalls the control endpoint instead of answering.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SYNC_REQ <= 1'b0;
            SYNC_ID <= 8'h00;
            EP0_STALL <= 1'b0;
        end else begin
            SYNC_REQ <= SETUP_VALID && req_ok && dir_in;
            if (SETUP_VALID && req_ok && dir_in) begin
                SYNC_ID <= cmd_report(req_code);
            end
            EP0_STALL <= SETUP_VALID && !req_ok;
        end
    end

    // -------------------------------------------------------------
    // Calibration store
    // -------------------------------------------------------------
    logic [15:0] cal_x_off_q;
    logic [15:0] cal_x_gain_q;
    logic [15:0] cal_y_off_q;
    logic [15:0] cal_y_gain_q;

    // Defaults map the full raw span onto the full unsigned span.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cal_x_off_q <= CAL_OFF_RST;
            cal_x_gain_q <= CAL_GAIN_RST;
            cal_y_off_q <= CAL_OFF_RST;
            cal_y_gain_q <= CAL_GAIN_RST;
        end else if (CAL_WE) begin
            cal_x_off_q <= CAL_X_OFF;
            cal_x_gain_q <= CAL_X_GAIN;
            cal_y_off_q <= CAL_Y_OFF;
            cal_y_gain_q <= CAL_Y_GAIN;
        end
    end

    // -------------------------------------------------------------
    // Coordinate report build
    // -------------------------------------------------------------
    logic [7:0] loop_q;
    logic was_touched_q;
    logic [COORD_BITS-1:0] pend_q;
    logic pend_v_q;
    logic [15:0] comp_x;
    logic [15:0] comp_y;
    logic [15:0] raw_x16;
    logic [15:0] raw_y16;
    logic [7:0] status_byte;
    logic send_now;
    tur_rep_if rep ();

    // Raw values are taken straight from the sensor, sign-extended.
    assign raw_x16 = 16'(signed'(RAW_X));
    assign raw_y16 = 16'(signed'(RAW_Y));
    assign comp_x = compensate(RAW_X, cal_x_off_q, cal_x_gain_q);
    assign comp_y = compensate(RAW_Y, cal_y_off_q, cal_y_gain_q);

    // Bit 7 always set, bit 6 tracks touch, the rest stay zero.
    always_comb begin
        status_byte = 8'h00;
        status_byte[STAT_ALWAYS] = 1'b1;
        status_byte[STAT_TOUCH] = TOUCHED;
    end

    // Every touched tick reports, plus the liftoff tick, so the host
    // sees both edges and the stream in between.
    assign send_now = SAMPLE_TICK && (TOUCHED || was_touched_q);

    // Counter stamps each tick and wraps at 256.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            loop_q <= LOOP_RST;
            was_touched_q <= 1'b0;
        end else if (SAMPLE_TICK) begin
            loop_q <= loop_q + 8'h01;
            was_touched_q <= TOUCHED;
        end
    end

    // The pending slot keeps only the newest frame. If the host drains
    // slowly an older frame is overwritten, which is the trade made to
    // avoid a queue: late coordinates are worth less than fresh ones.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            pend_q <= '0;
            pend_v_q <= 1'b0;
        end else if (send_now) begin
            // Byte k sits at bits 8k, all words low byte first.
            pend_q <= {raw_y16[15:8], raw_y16[7:0],
                       raw_x16[15:8], raw_x16[7:0],
                       comp_y[15:8], comp_y[7:0],
                       comp_x[15:8], comp_x[7:0],
                       status_byte, loop_q, RPT_COORD};
            pend_v_q <= 1'b1;
        end else if (rep.load && !rep.busy) begin
            pend_v_q <= 1'b0;
        end
    end

    // Loop count shown to other logic for matching its own outputs.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            LOOP_COUNT <= LOOP_RST;
        end else begin
            LOOP_COUNT <= loop_q;
        end
    end

    assign rep.load = pend_v_q;
    assign rep.frame = pend_q;

    // -------------------------------------------------------------
    // Report serialiser
    // -------------------------------------------------------------
    tur_report_ser u_ser (
        .clk(REF_CLK),
        .rst(RST),
        .rep(rep),
        .ready(REP_READY),
        .data_q(REP_DATA),
        .valid_q(REP_VALID),
        .last_q(REP_LAST)
    );

endmodule
`default_nettype wire

//--- hdl/tur_pkg.sv
// Shared constants for the touch request and report block.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package tur_pkg;

    // -------------------------------------------------------------
    // Setup packet layout (byte offsets and request-type fields)
    // -------------------------------------------------------------
    localparam int SETUP_BYTES = 8;
    localparam int OFS_REQ_TYPE = 0;
    localparam int OFS_REQUEST = 1;
    localparam int OFS_VALUE = 2;
    localparam int OFS_INDEX = 4;
    localparam int OFS_LENGTH = 6;
    localparam int BIT_DIR = 7;
    localparam int BIT_TYPE_HI = 6;
    localparam int BIT_TYPE_LO = 5;
    localparam int BIT_RECIP_HI = 4;
    localparam logic [1:0] TYPE_STANDARD = 2'h0;
    localparam logic [1:0] TYPE_CLASS = 2'h1;
    localparam logic [1:0] TYPE_VENDOR = 2'h2;
    localparam logic [4:0] RECIP_DEVICE = 5'h00;

    // -------------------------------------------------------------
    // Command codes and report identifiers
    // -------------------------------------------------------------
    localparam logic [7:0] CMD_CALIBRATE = 8'h04;
    localparam logic [7:0] CMD_STATUS = 8'h06;
    localparam logic [7:0] CMD_RESET = 8'h07;
    localparam logic [7:0] CMD_DEFAULTS = 8'h08;
    localparam logic [7:0] CMD_CTRL_ID = 8'h0a;
    localparam logic [7:0] CMD_READ_PARAM = 8'h10;
    localparam logic [7:0] RPT_COORD = 8'h01;
    localparam logic [7:0] RPT_PARAM = 8'h04;
    localparam logic [7:0] RPT_STATUS = 8'h06;
    localparam logic [7:0] RPT_CTRL_ID = 8'h0c;
    localparam logic [15:0] CAL_INSET = 16'h0001;
    localparam logic [15:0] CAL_CORNER = 16'h0002;

    // -------------------------------------------------------------
    // Coordinate report layout and reset values
    // -------------------------------------------------------------
    localparam int COORD_BYTES = 11;
    localparam int COORD_BITS = COORD_BYTES * 8;
    localparam int STAT_ALWAYS = 7;
    localparam int STAT_TOUCH = 6;
    localparam logic [7:0] LOOP_RST = 8'h00;
    localparam logic [15:0] CAL_OFF_RST = 16'he000;
    localparam logic [15:0] CAL_GAIN_RST = 16'h0400;
    localparam int CAL_FRAC = 8;
    localparam int RAW_W = 14;
endpackage

//--- hdl/tur_rep_if.sv
// Carrier between the report builder and the byte serialiser.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface tur_rep_if;
    import tur_pkg::*;
    logic load;
    logic [COORD_BITS-1:0] frame;
    logic busy;
    modport src (output load, output frame, input busy);
    modport ser (input load, input frame, output busy);
endinterface
`default_nettype wire

//--- hdl/tur_report_ser.sv
// Byte serialiser for the asynchronous coordinate report.
// Assumes the endpoint takes a byte in each cycle where valid and ready.
`timescale 1ns/100ps
`default_nettype none
module tur_report_ser
    import tur_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    tur_rep_if.ser rep,
    input wire logic ready,
    output logic [7:0] data_q,
    output logic valid_q,
    output logic last_q
);
    logic [COORD_BITS-1:0] shift_q;
    logic [3:0] left_q;

    // -------------------------------------------------------------
    // Shift out, byte 0 first, so every field leaves low byte first
    // -------------------------------------------------------------
    assign rep.busy = valid_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= '0;
            left_q <= 4'h0;
            data_q <= 8'h00;
            valid_q <= 1'b0;
            last_q <= 1'b0;
        end else if (rep.load && !valid_q) begin
            data_q <= rep.frame[7:0];
            shift_q <= rep.frame >> 8;
            left_q <= 4'(COORD_BYTES - 1);
            valid_q <= 1'b1;
            last_q <= 1'b0;
        end else if (valid_q && ready) begin
            data_q <= shift_q[7:0];
            shift_q <= shift_q >> 8;
            valid_q <= (left_q != 4'h0);
            last_q <= (left_q == 4'h1);
            left_q <= (left_q != 4'h0) ? left_q - 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

//--- sim/tur_top_chk.sv
// Concurrent checks on the ports of the touch request and report block.
// Assumes it is bound to tur_top and shares its clock and reset.
`timescale 1ns/100ps
`default_nettype none
module tur_top_chk
    import tur_pkg::*;
#(
    parameter logic [15:0] VENDOR_ID = 16'h0000
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic SETUP_VALID,
    input wire logic [63:0] SETUP_DATA,
    input wire logic CMD_PERMIT,
    input wire logic REP_READY,
    input wire logic [15:0] VID,
    input wire logic USB_REV11,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_LENGTH,
    input wire logic SYNC_REQ,
    input wire logic [7:0] SYNC_ID,
    input wire logic EP0_STALL,
    input wire logic [7:0] REP_DATA,
    input wire logic REP_VALID,
    input wire logic REP_LAST
);
    // ------------------------------------------------------------
    // Request and report properties
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    logic known;
    // A code outside the six listed ones must never be accepted.
    assign known = SETUP_DATA[15:8] inside {CMD_CALIBRATE, CMD_STATUS,
        CMD_RESET, CMD_DEFAULTS, CMD_CTRL_ID, CMD_READ_PARAM};
    property p_rev; USB_REV11 == 1'b1; endproperty
    a_rev: assert property (p_rev) else $error("rev flag low");
    property p_vid; VID == VENDOR_ID; endproperty
    a_vid: assert property (p_vid) else $error("vendor id wrong");
    property p_one; SETUP_VALID |=> CMD_VALID != EP0_STALL; endproperty
    a_one: assert property (p_one) else $error("no single answer");
    property p_code; SETUP_VALID && !known |=> EP0_STALL; endproperty
    a_code: assert property (p_code) else $error("bad code taken");
    property p_type;
        SETUP_VALID && SETUP_DATA[6:0] != 7'h40 |=> EP0_STALL;
    endproperty
    a_type: assert property (p_type) else $error("bad type taken");
    property p_perm; SETUP_VALID && !CMD_PERMIT |=> EP0_STALL; endproperty
    a_perm: assert property (p_perm) else $error("no permit taken");
    property p_fields;
        CMD_VALID |-> CMD_CODE == $past(SETUP_DATA[15:8])
            && CMD_LENGTH == $past(SETUP_DATA[63:48]);
    endproperty
    a_fields: assert property (p_fields) else $error("field moved");
    property p_sync;
        SYNC_REQ |-> CMD_VALID
            && (CMD_CODE == CMD_STATUS && SYNC_ID == RPT_STATUS
            || CMD_CODE == CMD_CTRL_ID && SYNC_ID == RPT_CTRL_ID
            || CMD_CODE == CMD_READ_PARAM && SYNC_ID == RPT_PARAM);
    endproperty
    a_sync: assert property (p_sync) else $error("sync id wrong");
    property p_hold;
        REP_VALID && !REP_READY |=> REP_VALID && $stable(REP_DATA)
            && $stable(REP_LAST);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_next;
        REP_VALID && REP_READY && REP_LAST |=> !REP_VALID
            || REP_DATA == RPT_COORD;
    endproperty
    a_next: assert property (p_next) else $error("frame start");
    c_sync: cover property (SYNC_REQ);
    c_stall: cover property (EP0_STALL);
    c_wait: cover property (REP_VALID && !REP_READY);
    c_last: cover property (REP_VALID && REP_READY && REP_LAST);
endmodule
bind tur_top tur_top_chk #(.VENDOR_ID(VENDOR_ID)) u_chk (.*);
`default_nettype wire

//--- sim/tur_host_model.sv
// Host side of the report endpoint: takes bytes and rebuilds frames.
// Assumes the same clock as the block; stall makes ready toggle.
`timescale 1ns/100ps
`default_nettype none
module tur_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic [7:0] rep_data,
    input wire logic rep_valid,
    input wire logic rep_last,
    output logic rep_ready,
    output logic [87:0] frame_q,
    output logic [15:0] count_q
);
    // ------------------------------------------------------------
    // Endpoint consumer
    // ------------------------------------------------------------
    logic [3:0] idx_q;
    // Toggling ready makes each byte after a frame's first wait a cycle, so held data gets exercised.
    always_ff @(posedge clk) begin
        if (rst) begin
            rep_ready <= 1'b0;
        end else begin
            rep_ready <= stall ? ~rep_ready : 1'b1;
        end
    end
    // Bytes land in arrival order, so a low-first field reads back whole.
    always_ff @(posedge clk) begin
        if (rst) begin
            idx_q <= 4'h0;
            frame_q <= '0;
            count_q <= 16'h0000;
        end else if (rep_valid && rep_ready) begin
            frame_q[idx_q*8 +: 8] <= rep_data;
            idx_q <= rep_last ? 4'h0 : idx_q + 4'h1;
            if (rep_last) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/tur_top_tb.sv
// Self-checking bench for the touch request and report block.
// Assumes the host model drains reports; all else is driven here.
`timescale 1ns/100ps
`default_nettype none
module tur_top_tb;
    import tur_pkg::*;
    localparam logic [15:0] VID_P = 16'h5a5a; // Arbitrary value.
    localparam logic [15:0] PN_P = 16'h0b01; // Arbitrary value.
    localparam logic [15:0] PS_P = 16'h0b02; // Arbitrary value.
    logic REF_CLK, RST, SPECIAL_MODE, SETUP_VALID, CMD_PERMIT, SAMPLE_TICK;
    logic TOUCHED, CAL_WE, REP_READY, USB_REV11, CMD_VALID, SYNC_REQ;
    logic EP0_STALL, REP_VALID, REP_LAST, stall;
    logic [63:0] SETUP_DATA;
    logic [13:0] RAW_X, RAW_Y;
    logic [15:0] CAL_X_OFF, CAL_X_GAIN, CAL_Y_OFF, CAL_Y_GAIN, VID, PID;
    logic [15:0] CMD_VALUE, CMD_INDEX, CMD_LENGTH, xo, xg, yo, yg, count;
    logic [7:0] CMD_CODE, SYNC_ID, LOOP_COUNT, REP_DATA;
    logic [87:0] frame_q;
    int error_cnt = 0;
    int checks = 0;
    int ticks = 0;
    tur_top #(.VENDOR_ID(VID_P), .PID_NORMAL(PN_P), .PID_SPECIAL(PS_P)) dut (.*);
    tur_host_model host (.clk(REF_CLK), .rst(RST), .stall(stall),
        .rep_data(REP_DATA), .rep_valid(REP_VALID), .rep_last(REP_LAST),
        .rep_ready(REP_READY), .frame_q(frame_q), .count_q(count));
    // ------------------------------------------------------------
    // Checking and access tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] s, e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Reference decode, kept apart from the design on purpose.
    task automatic req(input logic [7:0] t, c,
        input logic [15:0] v = 16'h0, i = 16'h0, l = 16'h0,
        input logic p = 1'b1);
        logic ok, rd;
        rd = c inside {CMD_STATUS, CMD_CTRL_ID, CMD_READ_PARAM};
        ok = p && t == {rd, 7'h40} && (rd || l == 16'h0)
            && (rd || c inside {CMD_CALIBRATE, CMD_RESET, CMD_DEFAULTS})
            && (c != CMD_CALIBRATE || v inside {16'h1, 16'h2});
        @(posedge REF_CLK);
        SETUP_VALID <= 1'b1;
        SETUP_DATA <= {l, i, v, c, t};
        CMD_PERMIT <= p;
        @(posedge REF_CLK);
        SETUP_VALID <= 1'b0;
        #1;
        chk("accepted", CMD_VALID, ok);
        chk("stall", EP0_STALL, !ok);
        chk("sync request", SYNC_REQ, ok && rd);
        if (ok) begin
            chk("code", CMD_CODE, c);
            chk("value", CMD_VALUE, v);
            chk("index", CMD_INDEX, i);
            chk("length", CMD_LENGTH, l);
        end
        if (ok && rd) begin
            chk("sync id", SYNC_ID, c == 8'h06 ? 8'h06 :
                c == 8'h0a ? 8'h0c : 8'h04);
        end
    endtask
    // Compensated value: clamp of (raw - offset) * gain over 256.
    function automatic logic [15:0] comp(input logic [13:0] r,
        input logic [15:0] o, g);
        longint p;
        p = (longint'($signed(r)) - longint'($signed(o))) * longint'(g) >>> 8;
        return p < 0 ? 16'h0 : p > 65535 ? 16'hffff : p[15:0];
    endfunction
    task automatic cal(input logic [15:0] a, b, c, d);
        @(posedge REF_CLK);
        CAL_WE <= 1'b1;
        {CAL_X_OFF, CAL_X_GAIN, CAL_Y_OFF, CAL_Y_GAIN} <= {a, b, c, d};
        @(posedge REF_CLK);
        CAL_WE <= 1'b0;
        {xo, xg, yo, yg} = {a, b, c, d};
    endtask
    task automatic tick(input logic t, input logic [13:0] x, y);
        @(posedge REF_CLK);
        SAMPLE_TICK <= 1'b1;
        {TOUCHED, RAW_X, RAW_Y} <= {t, x, y};
        @(posedge REF_CLK);
        SAMPLE_TICK <= 1'b0;
        ticks++;
    endtask
    // One tick, then the whole frame is compared byte by byte.
    task automatic frame(input logic t, input logic [13:0] x, y);
        logic [87:0] e;
        logic [15:0] n;
        e = {{{2{y[13]}}, y}, {{2{x[13]}}, x}, comp(y, yo, yg),
            comp(x, xo, xg), 1'b1, t, 6'h00, 8'(ticks), RPT_COORD};
        n = count;
        tick(t, x, y);
        for (int k = 0; k < 200 && count == n; k++) @(posedge REF_CLK);
        #1;
        chk("frame count", count, n + 16'h1);
        chk("loop count", LOOP_COUNT, 8'(ticks));
        for (int b = 0; b < COORD_BYTES; b++) begin
            chk("frame byte", frame_q[8*b +: 8], e[8*b +: 8]);
        end
    endtask
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    initial begin
        repeat (20000) @(posedge REF_CLK);
        error_cnt++;
        stop_test();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {RST, CMD_PERMIT} = 2'b11;
        {SPECIAL_MODE, SETUP_VALID, SAMPLE_TICK, TOUCHED, CAL_WE} = '0;
        {stall, SETUP_DATA, RAW_X, RAW_Y} = '0;
        {CAL_X_OFF, CAL_X_GAIN, CAL_Y_OFF, CAL_Y_GAIN} = '0;
        {xo, xg, yo, yg} = {CAL_OFF_RST, CAL_GAIN_RST, CAL_OFF_RST,
            CAL_GAIN_RST};
        repeat (10) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        #1;
        chk("pid", PID, PN_P);
        chk("usb rev", USB_REV11, 1'b1);
        frame(1'b1, 14'h2000, 14'h1fff);
        req(8'h40, CMD_RESET);
        req(8'h40, CMD_CALIBRATE, CAL_INSET);
        req(8'h40, CMD_CALIBRATE, CAL_CORNER);
        req(8'hc0, CMD_STATUS, 16'h0, 16'h0, 16'h0014);
        req(8'h40, CMD_DEFAULTS);
        req(8'hc0, CMD_CTRL_ID, 16'h0, 16'h0, 16'h0002);
        req(8'hc0, CMD_READ_PARAM, 16'h1234, 16'h00a5, 16'h0008);
        req(8'h40, 8'h05);
        req(8'hc0, 8'h11);
        for (int ty = 0; ty < 4; ty++) begin
            req({1'b0, 2'(ty), 5'h0}, CMD_RESET);
        end
        req(8'h41, CMD_RESET);
        req(8'h40, CMD_STATUS);
        req(8'h40, CMD_RESET, 16'h0, 16'h0, 16'h0002);
        req(8'h40, CMD_CALIBRATE, 16'h0003);
        for (int i = 0; i < 6; i++) begin
            @(posedge REF_CLK);
            SETUP_VALID <= 1'b1;
            SETUP_DATA <= {48'h0, 8'(i + 3), 8'h40};
        end
        @(posedge REF_CLK);
        SETUP_VALID <= 1'b0;
        req(8'h40, CMD_RESET, 16'h0, 16'h0, 16'h0, 1'b0);
        stall <= 1'b1;
        frame(1'b1, 14'h0000, 14'h3fff);
        frame(1'b1, 14'h0001, 14'h1000);
        stall <= 1'b0;
        frame(1'b0, 14'h0002, 14'h0003);
        for (int k = 0; k < 252; k++) tick(1'b0, 14'h0, 14'h0);
        repeat (30) @(posedge REF_CLK);
        chk("idle frames", count, 16'd4);
        cal(16'h0000, 16'h1000, 16'hf000, 16'h0100);
        frame(1'b1, 14'h1fff, 14'h2000);
        frame(1'b1, 14'h0010, 14'h0000);
        SPECIAL_MODE <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        #1;
        chk("pid special", PID, PS_P);
        stop_test();
    end
endmodule
`default_nettype wire
